// *** design/tzp_top.sv ***
// Timer with selectable count clock, prescaler, postscaler and sleep control.
// Assumes an Avalon-MM master on SYS_CLK and clock sources arriving as pins.
`timescale 1ns/1ps
`default_nettype none
`include "tzp_defines.svh"

// Summary of operation
// - A three-bit field of the second control register picks the count clock source.
// - An internal source makes the timer advance once per prescaled group of clock periods.
// - An external source makes the timer advance once per prescaled group of rising edges.
// - The prescaler divides by a power of two from 1 to 32768 chosen by a four-bit field.
// - The prescaler is hidden and is cleared by writes to the counter low byte or second control.
// - The postscaler divides timer events by 1 to 16 set by a four-bit field of the first control.
// - The postscaler is hidden and is reset by writes to the counter low byte or first control.
// - In synchronous operation the timer stops counting during sleep.
// - In asynchronous operation the timer keeps counting in sleep and wakes the device if enabled.
// - An event occurs on low byte matching the compare byte, or on 16-bit rollover from FFFF.
// - The event flag is set once per postscale setting plus one events.
// - The timer output toggles on each postscaled event, giving a 50% square wave.
// - With the interrupt enable set, a set flag raises the interrupt request.
module tzp_top
    import tzp_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Avalon-MM slave
    input wire logic [`TZP_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Count clock sources and power state
    input wire logic [NUM_SRC-1:0] CLK_SRC,
    input wire logic SLEEP,
    // Timer outputs
    output logic TMR_OUT,
    output logic IRQ,
    output logic WAKE
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    tzp_byte_t timer_control_first;
    tzp_byte_t timer_control_second;
    tzp_byte_t counter_low_byte;
    tzp_byte_t counter_high_compare_byte;
    logic timer_event_flag;
    logic timer_event_irq_enable;
    logic wr_acc;
    logic rd_acc;
    logic wr_low;
    tzp_word_t counter_full_word;

    // Byte-lane zero write data
    tzp_byte_t wdata;
    assign wdata = AVS_WRITEDATA[7:0];

    // Address hit, used by both the write and the read decode
    function automatic logic reg_hit(input logic [`TZP_ADDR_W-1:0] addr,
                                     input logic [`TZP_ADDR_W-1:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // One wait state: the access completes on the edge after it is seen
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        end
    end

    assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    assign rd_acc = AVS_READ && AVS_WAITREQUEST;
    assign wr_low = wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_COUNT_LOW);

    // Read data registered during the wait state; unmapped reads give zero
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_READDATA <= `TZP_RST_WORD;
        end else if (rd_acc) begin
            AVS_READDATA <= `TZP_RST_WORD;
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_FIRST)) begin
                AVS_READDATA[7:0] <= timer_control_first;
                AVS_READDATA[`TZP_F1_OUT] <= TMR_OUT;
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_SECOND)) begin
                AVS_READDATA[7:0] <= timer_control_second;
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_COUNT_LOW)) begin
                AVS_READDATA[7:0] <= counter_low_byte;
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_COUNT_HIGH)) begin
                AVS_READDATA[7:0] <= counter_high_compare_byte;
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_IRQ)) begin
                AVS_READDATA[`TZP_IRQ_FLAG] <= timer_event_flag;
                AVS_READDATA[`TZP_IRQ_EN] <= timer_event_irq_enable;
            end
        end
    end

    // Control registers; the output status bit is read-only
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_control_first <= `TZP_RST_BYTE;
            timer_control_second <= `TZP_RST_BYTE;
            timer_event_irq_enable <= 1'b0;
        end else if (wr_acc) begin
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_FIRST)) begin
                timer_control_first <= wdata & ~(8'h01 << `TZP_F1_OUT);
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_SECOND)) begin
                timer_control_second <= wdata;
            end
            if (reg_hit(AVS_ADDRESS, `TZP_OFS_IRQ)) begin
                timer_event_irq_enable <= wdata[`TZP_IRQ_EN];
            end
        end
    end

    // Field views
    logic enable;
    logic mode16;
    logic async_mode;
    tzp_cs_t count_clock_select;
    assign enable = timer_control_first[`TZP_F1_ENABLE];
    assign mode16 = timer_control_first[`TZP_F1_MODE16];
    assign async_mode = timer_control_second[`TZP_F2_ASYNC];
    assign count_clock_select = timer_control_second[`TZP_F2_CS_MSB:`TZP_F2_CS_LSB];

    // ------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------
    // Pins pass two flops; a third holds the previous level for edges
    logic [NUM_SRC-1:0] src_meta;
    logic [NUM_SRC-1:0] src_sync;
    logic [NUM_SRC-1:0] src_prev;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            src_meta <= '0;
            src_sync <= '0;
            src_prev <= '0;
        end else begin
            src_meta <= CLK_SRC;
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    // source select; system clock counts every cycle; rising edges
    logic src_tick;
    logic [NUM_SRC-1:0] src_rise;
    assign src_rise = src_sync & ~src_prev;
    assign src_tick = (count_clock_select == `TZP_CS_SYSCLK) ? 1'b1
                      : src_rise[count_clock_select];

    // synchronous halt; asynchronous keeps counting in sleep
    logic run;
    assign run = enable && !(SLEEP && !async_mode);

    // ------------------------------------------------------------------
    // Divide stages
    // ------------------------------------------------------------------
    tzp_scale_if pre_if();
    tzp_scale_if post_if();
    logic timer_event;

    // prescaler clear on low byte or second control write
    assign pre_if.clear = wr_low || (wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_SECOND));
    assign pre_if.tick = src_tick && run;
    assign pre_if.sel = timer_control_second[`TZP_F2_PRE_MSB:`TZP_F2_PRE_LSB];
    // postscaler clear on low byte or first control write
    assign post_if.clear = wr_low || (wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_CTRL_FIRST));
    assign post_if.tick = timer_event;
    assign post_if.sel = timer_control_first[`TZP_F1_POST_MSB:`TZP_F1_POST_LSB];

    tzp_prescaler #(.WIDTH(`TZP_PRE_WIDTH)) u_pre (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .ps(pre_if.scaler)
    );

    tzp_postscaler u_post (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .ps(post_if.scaler)
    );

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic count_tick;
    logic low_match;
    assign count_tick = pre_if.pulse;
    assign counter_full_word = {counter_high_compare_byte, counter_low_byte};
    assign low_match = (counter_low_byte == counter_high_compare_byte);
    // match or rollover event; a low byte write in the same cycle drops it
    assign timer_event = count_tick && !wr_low
                         && (mode16 ? (counter_full_word == `TZP_COUNT_MAX) : low_match);

    // Software writes win over counting so a loaded value is never skipped
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            counter_low_byte <= `TZP_RST_BYTE;
            counter_high_compare_byte <= `TZP_RST_BYTE;
        end else begin
            if (wr_low) begin
                counter_low_byte <= wdata;
            end else if (count_tick) begin
                if (mode16) begin
                    counter_low_byte <= counter_low_byte + 8'h01;
                end else if (low_match) begin
                    counter_low_byte <= `TZP_RST_BYTE;
                end else begin
                    counter_low_byte <= counter_low_byte + 8'h01;
                end
            end
            if (wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_COUNT_HIGH)) begin
                counter_high_compare_byte <= wdata;
            end else if (count_tick && mode16 && !wr_low && counter_low_byte == 8'hFF) begin
                counter_high_compare_byte <= counter_high_compare_byte + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flag, output and requests
    // ------------------------------------------------------------------
    // flag per postscaled event; set beats a write-one clear
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_event_flag <= 1'b0;
        end else if (post_if.pulse) begin
            timer_event_flag <= 1'b1;
        end else if (wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_IRQ) && wdata[`TZP_IRQ_FLAG]) begin
            timer_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TMR_OUT <= 1'b0;
        end else if (post_if.pulse) begin
            TMR_OUT <= !TMR_OUT;
        end
    end

    // interrupt request; wake only for asynchronous sleep
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            IRQ <= timer_event_flag && timer_event_irq_enable;
            WAKE <= SLEEP && async_mode && timer_event_flag && timer_event_irq_enable;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    property p_sleep_halt;
        (SLEEP && !async_mode && !wr_acc) |=> $stable(counter_full_word);
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("counter moved in sync sleep");

    property p_wake;
        (SLEEP && async_mode && timer_event_flag && timer_event_irq_enable) |=> WAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake in async sleep");

    property p_rollover;
        (mode16 && count_tick && !wr_low && counter_full_word == 16'hFFFF) |-> timer_event;
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover gave no event");

    property p_flag_set;
        post_if.pulse |=> timer_event_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

    property p_toggle;
        post_if.pulse |=> (TMR_OUT != $past(TMR_OUT));
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");

    // Request follows flag and enable one cycle late, in both directions
    property p_irq;
        IRQ == $past(timer_event_flag && timer_event_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");

    property p_match_wrap;
        (!mode16 && count_tick && low_match && !wr_low) |=> (counter_low_byte == 8'h00);
    endproperty
    a_match_wrap: assert property (p_match_wrap) else $error("low byte did not wrap");

    property p_sys_src;
        (count_clock_select == `TZP_CS_SYSCLK && run) |-> pre_if.tick;
    endproperty
    a_sys_src: assert property (p_sys_src) else $error("system clock source idle");

    property p_bus_answer;
        ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_event8: cover property (!mode16 && timer_event);
    c_rollover: cover property (mode16 && timer_event);
    c_wake: cover property (WAKE);
    c_set_clear: cover property (post_if.pulse && wr_acc && reg_hit(AVS_ADDRESS, `TZP_OFS_IRQ));
endmodule
`default_nettype wire

// *** include/tzp_defines.svh ***
// Register offsets, field positions and reset values of the timer block.
// Assumes byte addressing on a 32-bit register bus, one register per word.
`ifndef TZP_DEFINES_SVH
`define TZP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TZP_ADDR_W 5
`define TZP_OFS_CTRL_FIRST 5'h00
`define TZP_OFS_CTRL_SECOND 5'h04
`define TZP_OFS_COUNT_LOW 5'h08
`define TZP_OFS_COUNT_HIGH 5'h0C
`define TZP_OFS_IRQ 5'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TZP_F1_ENABLE 7
`define TZP_F1_OUT 5
`define TZP_F1_MODE16 4
`define TZP_F1_POST_MSB 3
`define TZP_F1_POST_LSB 0
`define TZP_F2_CS_MSB 7
`define TZP_F2_CS_LSB 5
`define TZP_F2_ASYNC 4
`define TZP_F2_PRE_MSB 3
`define TZP_F2_PRE_LSB 0
`define TZP_IRQ_FLAG 0
`define TZP_IRQ_EN 1

// ----------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------
`define TZP_RST_BYTE 8'h00
`define TZP_RST_WORD 32'h0000_0000
`define TZP_CS_SYSCLK 3'h1
`define TZP_COUNT_MAX 16'hFFFF
`define TZP_PRE_WIDTH 15
`define TZP_SYNC_STAGES 2

`endif

// *** include/tzp_pkg.sv ***
// Types shared by the timer block and its scaler modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tzp_pkg;
    typedef logic [7:0] tzp_byte_t;
    typedef logic [3:0] tzp_sel_t;
    typedef logic [2:0] tzp_cs_t;
    typedef logic [15:0] tzp_word_t;
endpackage

// *** include/tzp_scale_if.sv ***
// Carrier between the timer core and one of its divide stages.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface tzp_scale_if;
    import tzp_pkg::*;
    logic tick;
    logic clear;
    tzp_sel_t sel;
    logic pulse;
    modport core(output tick, output clear, output sel, input pulse);
    modport scaler(input tick, input clear, input sel, output pulse);
endinterface
`default_nettype wire

// *** design/tzp_prescaler.sv ***
// Power-of-two prescaler for the timer count clock.
// Assumes tick is a single-cycle enable on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tzp_defines.svh"
module tzp_prescaler
    import tzp_pkg::*;
#(
    parameter int WIDTH = `TZP_PRE_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Divide stage
    tzp_scale_if.scaler ps
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] mask;

    // Low sel bits all ones marks the last tick of a period
    assign mask = ~({WIDTH{1'b1}} << ps.sel);
    assign ps.pulse = ps.tick && ((count & mask) == mask);

    // Hidden count; clearing wins over a tick in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (ps.clear) begin
            count <= '0;
        end else if (ps.tick) begin
            count <= count + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_pre_ratio;
        (ps.tick && !ps.clear && ps.sel == 4'h0) |-> ps.pulse;
    endproperty
    a_pre_ratio: assert property (p_pre_ratio) else $error("prescaler 1:1 missed a tick");

    property p_pre_clear;
        ps.clear |=> (count == '0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");
endmodule
`default_nettype wire

// *** design/tzp_postscaler.sv ***
// Output postscaler dividing timer events by sel plus one.
// Assumes tick is a single-cycle event on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tzp_defines.svh"
module tzp_postscaler
    import tzp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Divide stage
    tzp_scale_if.scaler ps
);
    tzp_sel_t count;

    assign ps.pulse = ps.tick && (count == ps.sel);

    // Hidden count restarts after each output pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (ps.clear) begin
            count <= '0;
        end else if (ps.tick) begin
            count <= ps.pulse ? 4'h0 : count + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_post_ratio;
        ps.pulse |-> (count == ps.sel);
    endproperty
    a_post_ratio: assert property (p_post_ratio) else $error("postscaler pulse off ratio");

    property p_post_clear;
        ps.clear |=> (count == 4'h0);
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("postscaler not reset");
endmodule
`default_nettype wire

// *** tb/tzp_src_model.sv ***
// Model of the count clock pins feeding the timer.
// Assumes the bench chooses which pins run; idle pins hold their level.
`timescale 1ns/1ps
`default_nettype none
module tzp_src_model #(
    parameter int HALF_NS = 20
) (
    // Control from the bench
    input wire logic [7:0] run,
    // Clock pins
    output logic [7:0] pins
);
    // Offset start keeps pin edges away from the system clock edges
    initial begin
        pins = 8'h00;
        #3;
        forever begin
            pins = pins ^ run;
            #(HALF_NS);
        end
    end
endmodule
`default_nettype wire

// *** tb/tzp_top_test.sv ***
// Self-checking bench for the timer block over its register bus.
// Assumes the pin model drives the count clock inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module tzp_top_test;
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic sleep = 1'b0;
    logic [7:0] run = 8'h00;
    logic [31:0] rdata;
    logic wait_req;
    logic tmr_out;
    logic irq;
    logic wake;
    logic [7:0] pins;
    logic prev = 1'b0;
    logic [31:0] d;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int tog_cnt = 0;
    int n;
    int t0;

    // ----------------------------------------------------------------
    // Clock, design and pin model
    // ----------------------------------------------------------------
    always #5 SYS_CLK = ~SYS_CLK;

    tzp_top #(.NUM_SRC(8)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .CLK_SRC(pins), .SLEEP(sleep),
        .TMR_OUT(tmr_out), .IRQ(irq), .WAKE(wake));

    tzp_src_model #(.HALF_NS(20)) src (.run(run), .pins(pins));

    // Cycle and output toggle counters, updated late so reads see settled values
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        prev <= tmr_out;
        if (tmr_out !== prev) begin
            tog_cnt <= tog_cnt + 1;
        end
    end

    // ----------------------------------------------------------------
    // Bus and measurement tasks
    // ----------------------------------------------------------------
    // One access; request held until waitrequest is seen low at an edge
    task automatic access(input logic [4:0] a, input logic w, input logic [7:0] v,
                          input logic [3:0] b);
        int k;
        k = 0;
        @(posedge SYS_CLK);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h000000, v};
        be <= b;
        do begin
            @(posedge SYS_CLK);
            k++;
        end while (wait_req !== 1'b0 && k < 100);
        if (k >= 100) begin
            miscompares++;
            $display("[FAIL] %0t bus answer timeout", $time);
        end
        d = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
        access(a, 1'b1, v, 4'hF);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        access(a, 1'b0, 8'h00, 4'hF);
        `CHK(d, e)
    endtask

    // Cycles until the timer output changes; bounded for the longest ratio
    task automatic tog(output int c);
        logic last;
        last = tmr_out;
        c = 0;
        do begin
            @(posedge SYS_CLK);
            c++;
        end while (tmr_out === last && c < 70000);
        if (c >= 70000) begin
            miscompares++;
            $display("[FAIL] %0t output toggle timeout", $time);
        end
    endtask

    // Stop, set up and start the timer with the low byte at zero
    task automatic cfg(input logic [7:0] c2, input logic [7:0] cmp, input logic [7:0] c1);
        wr_reg(5'h00, 8'h00);
        wr_reg(5'h04, c2);
        wr_reg(5'h0C, cmp);
        wr_reg(5'h08, 8'h00);
        wr_reg(5'h00, c1);
    endtask

    // Toggle interval equals compare plus one, times prescale, times postscale
    task automatic per(input logic [7:0] c2, input logic [7:0] cmp, input logic [7:0] c1,
                       input int e);
        cfg(c2, cmp, c1);
        tog(n);
        tog(n);
        `CHK(n, e)
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog sized above the longest divide ratio run twice
    initial begin
        repeat (95000) @(posedge SYS_CLK);
        miscompares++;
        give_verdict;
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd_chk(5'(i * 4), 32'h0000_0000);
        end
        rd_chk(5'h14, 32'h0000_0000);
        access(5'h0C, 1'b1, 8'h55, 4'h0);
        rd_chk(5'h0C, 32'h0000_0000);
        $display("test reset done");
        per(8'h20, 8'h09, 8'h80, 10);
        per(8'h22, 8'h04, 8'h81, 40);
        per(8'h23, 8'h01, 8'h8F, 256);
        per(8'h2F, 8'h00, 8'h80, 32768);
        $display("test ratios done");
        // Mid-period control write must restart the event division
        cfg(8'h20, 8'h09, 8'h81);
        tog(n);
        t0 = cyc;
        repeat (12) @(posedge SYS_CLK);
        wr_reg(5'h00, 8'h81);
        tog(n);
        `CHK(cyc - t0, 30)
        // Repeated writes keep the prescaler from ever reaching its ratio
        cfg(8'h22, 8'h04, 8'h80);
        tog(n);
        // Let the counter take in the toggle just seen before the snapshot
        @(posedge SYS_CLK);
        t0 = tog_cnt;
        repeat (20) wr_reg(5'h04, 8'h22);
        `CHK(tog_cnt - t0, 0)
        $display("test clears done");
        wr_reg(5'h00, 8'h00);
        rd_chk(5'h10, 32'h0000_0001);
        `CHK(irq, 1'b0)
        wr_reg(5'h10, 8'h02);
        repeat (2) @(posedge SYS_CLK);
        `CHK(irq, 1'b1)
        wr_reg(5'h10, 8'h03);
        repeat (2) @(posedge SYS_CLK);
        `CHK(irq, 1'b0)
        rd_chk(5'h10, 32'h0000_0002);
        $display("test irq done");
        cfg(8'h20, 8'hFF, 8'h00);
        wr_reg(5'h08, 8'hF0);
        t0 = cyc;
        wr_reg(5'h00, 8'h90);
        tog(n);
        `CHK((cyc - t0) inside {[17:24]}, 1'b1)
        rd_chk(5'h0C, 32'h0000_0000);
        $display("test wide done");
        cfg(8'h20, 8'h09, 8'h80);
        sleep <= 1'b1;
        repeat (5) @(posedge SYS_CLK);
        t0 = tog_cnt;
        repeat (100) @(posedge SYS_CLK);
        `CHK(tog_cnt - t0, 0)
        run <= 8'h04;
        cfg(8'h50, 8'h04, 8'h80);
        tog(n);
        tog(n);
        `CHK(n, 20)
        repeat (2) @(posedge SYS_CLK);
        `CHK(wake, 1'b1)
        sleep <= 1'b0;
        run <= 8'h00;
        $display("test sleep done");
        give_verdict;
    end
endmodule
`default_nettype wire
